// >>> hdl/anpr_match.sv
module anpr_match
   import anpr_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // received link code words
   input  wire logic        i_word_valid,
   input  wire logic [15:0] i_word,
   input  wire logic        i_word_is_next,
   // stored page
   output logic             o_stored,
   output logic [15:0]      o_word,
   output logic             o_is_next
);

   typedef struct packed {
      logic [15:0] last;
      logic        last_next;
      logic [1:0]  count;
      logic        stored;
   } anpr_match_state_type;

   anpr_match_state_type st_ff;
   anpr_match_state_type nxt_st;

   // ****************************************
   // consecutive identical word counter
   // ****************************************
   always_comb begin
      nxt_st        = st_ff;
      nxt_st.stored = 1'b0;
      if (i_word_valid) begin
         if (i_word == st_ff.last && i_word_is_next == st_ff.last_next
             && st_ff.count != 2'h0) begin
            // saturate so one burst of repeats stores only once
            if (st_ff.count != MATCH_NEEDED) begin
               nxt_st.count = st_ff.count + 2'h1;
               if (st_ff.count + 2'h1 == MATCH_NEEDED) begin
                  nxt_st.stored = 1'b1;
               end
            end
         end else begin
            nxt_st.last      = i_word;
            nxt_st.last_next = i_word_is_next;
            nxt_st.count     = 2'h1;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign o_stored  = st_ff.stored;
   assign o_word    = st_ff.last;
   assign o_is_next = st_ff.last_next;

endmodule

// >>> hdl/anpr_pkg.sv
package anpr_pkg;

   // ****************************************
   // management addresses
   // ****************************************
   localparam logic [4:0]  ADDR_ADVERTISE     = 5'h04;
   localparam logic [4:0]  ADDR_PARTNER       = 5'h05;
   localparam logic [4:0]  ADDR_EXPANSION     = 5'h06;
   localparam logic [4:0]  ADDR_NEXT_PAGE_TX  = 5'h07;
   localparam logic [4:0]  ADDR_VENDOR_LO     = 5'h10;
   localparam logic [4:0]  ADDR_VENDOR_HI     = 5'h1d;

   // ****************************************
   // advertisement fields
   // ****************************************
   localparam int          ADV_MORE_PAGES_POS = 15;
   localparam int          ADV_REMOTE_FLT_POS = 13;
   localparam int          ADV_PAUSE_POS      = 10;
   localparam int          ADV_ABILITY_LSB    = 5;
   localparam logic [4:0]  STANDARD_SELECTOR  = 5'h01;
   localparam logic [15:0] ADV_RESET          = 16'h0001;
   localparam logic [15:0] ADV_WRITE_MASK     = 16'ha7e0;

   // ****************************************
   // link code word fields (partner and next page)
   // ****************************************
   localparam int          LCW_MORE_PAGES_POS = 15;
   localparam int          LCW_ACK_POS        = 14;
   localparam int          LCW_MSG_SEL_POS    = 13;
   localparam int          LCW_SECOND_ACKNOWLEDGE_POS       = 12;
   localparam int          LCW_TOGGLE_POS     = 11;
   localparam int          LCW_CODE_WIDTH     = 11;
   localparam logic [15:0] PARTNER_RESET      = 16'h0000;

   // ****************************************
   // expansion fields
   // ****************************************
   localparam int          EXP_PDF_POS        = 4;
   localparam int          EXP_PARTNER_NP_POS = 3;
   localparam int          EXP_LOCAL_NP_POS   = 2;
   localparam int          EXP_PAGE_RX_POS    = 1;
   localparam int          EXP_PARTNER_AN_POS = 0;
   localparam logic        LOCAL_NEXTPAGE_ABLE = 1'b1;

   // ****************************************
   // next page transmit
   // ****************************************
   localparam logic [15:0] NPT_NULL_PAGE      = 16'h2001;
   localparam logic [15:0] NPT_WRITE_MASK     = 16'hb7ff;
   localparam logic        TOGGLE_FIRST       = 1'b1;

   // ****************************************
   // page receive
   // ****************************************
   localparam logic [1:0]  MATCH_NEEDED       = 2'h3;

endpackage

// >>> hdl/anpr_top.sv
// Operation
// - selector loads standard value at power-up
// - abilities initialised from status capability bits
// - four registers at addresses four to seven
// - pause bit only reaches transmitted word
// - partner register read-only, written on receipt
// - partner shows base or next page
// - base page fields stored, four-pair kept
// - next page word field layout
// - toggle inverts previous transmitted toggle
// - second acknowledge only when task possible
// - parallel detect fault set; read clears
// - page received after three identical words
// - expansion reports partner abilities
// - expansion reports local next page ability
// - null message page unless management loaded
// - exchange ends when both sides finish
// - expansion writes have no effect
// - vendor registers only through management port
// - contents valid once negotiation complete
module anpr_top
   import anpr_pkg::*;
(
   // clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rstn,
   // management register port
   input  wire logic [4:0]  i_mi_addr,
   input  wire logic        i_mi_rd,
   input  wire logic        i_mi_wr,
   input  wire logic [15:0] i_mi_wdata,
   output logic [15:0]      o_mi_rdata,
   output logic             o_mi_rvalid,
   // vendor register bank
   input  wire logic [15:0] i_vendor_rdata,
   output logic             o_vendor_sel,
   // negotiation process
   input  wire logic [4:0]  i_status_caps,
   input  wire logic        i_an_start,
   input  wire logic        i_an_complete,
   input  wire logic        i_rx_valid,
   input  wire logic [15:0] i_rx_word,
   input  wire logic        i_rx_is_next,
   input  wire logic        i_wait_done,
   input  wire logic [2:0]  i_detect_ready,
   input  wire logic        i_tx_page_sent,
   // words and status toward the negotiation process
   output logic [15:0]      o_tx_base_word,
   output logic [15:0]      o_tx_next_word,
   output logic             o_local_np_able,
   output logic             o_page_received,
   output logic             o_partner_is_next,
   output logic             o_np_done,
   output logic             o_page_valid
);

   typedef struct packed {
      logic        init_done;
      logic [15:0] adv;
      logic [15:0] partner;
      logic        partner_next;
      logic        partner_np;
      logic        partner_an;
      logic        pdf;
      logic        prx;
      logic [15:0] npt;
      logic        npt_loaded;
      logic        toggle;
      logic        np_done;
      logic [15:0] rdata;
      logic        rvalid;
      logic        vendor_sel;
      logic [15:0] tx_base;
      logic [15:0] tx_next;
      logic        page_valid;
   } anpr_state_type;

   anpr_state_type st_ff;
   anpr_state_type nxt_st;

   logic        page_stored;
   logic [15:0] page_word;
   logic        page_is_next;
   logic        one_ready;
   logic [15:0] exp_value;
   logic [15:0] npt_view;

   // ****************************************
   // page receive filter
   // ****************************************
   anpr_match u_match (
      .i_clk          (i_clk),
      .i_rstn         (i_rstn),
      .i_word_valid   (i_rx_valid),
      .i_word         (i_rx_word),
      .i_word_is_next (i_rx_is_next),
      .o_stored       (page_stored),
      .o_word         (page_word),
      .o_is_next      (page_is_next)
   );

   // ****************************************
   // derived views
   // ****************************************
   always_comb begin
      one_ready = (i_detect_ready == 3'h1) || (i_detect_ready == 3'h2)
                  || (i_detect_ready == 3'h4);
      exp_value = '0;
      exp_value[EXP_PDF_POS]        = st_ff.pdf;
      exp_value[EXP_PARTNER_NP_POS] = st_ff.partner_np;
      exp_value[EXP_LOCAL_NP_POS]   = LOCAL_NEXTPAGE_ABLE;
      exp_value[EXP_PAGE_RX_POS]    = st_ff.prx;
      exp_value[EXP_PARTNER_AN_POS] = st_ff.partner_an;
      // toggle shown is the device's own
      npt_view                 = st_ff.npt;
      npt_view[LCW_TOGGLE_POS] = st_ff.toggle;
   end

   // ****************************************
   // register file and page handling
   // ****************************************
   always_comb begin
      nxt_st            = st_ff;
      nxt_st.rvalid     = 1'b0;
      nxt_st.vendor_sel = 1'b0;

      if (!st_ff.init_done) begin
         nxt_st.adv[ADV_ABILITY_LSB +: 5] = i_status_caps;
         nxt_st.init_done                 = 1'b1;
      end

      // write decode, addresses four and seven
      if (i_mi_wr) begin
         unique case (i_mi_addr)
            ADDR_ADVERTISE: begin
               nxt_st.adv = (i_mi_wdata & ADV_WRITE_MASK)
                            | (st_ff.adv & ~ADV_WRITE_MASK);
            end
            ADDR_NEXT_PAGE_TX: begin
               nxt_st.npt        = (i_mi_wdata & NPT_WRITE_MASK)
                                   | (st_ff.npt & ~NPT_WRITE_MASK);
               nxt_st.npt_loaded = 1'b1;
            end
            default: begin
            end
         endcase
      end

      nxt_st.adv[4:0] = STANDARD_SELECTOR;

      // read path; clears go first so a same-cycle event survives
      if (i_mi_rd) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata  = '0;
         if (i_mi_addr == ADDR_ADVERTISE) begin
            nxt_st.rdata = st_ff.adv;
         end else if (i_mi_addr == ADDR_PARTNER) begin
            nxt_st.rdata = st_ff.partner;
         end else if (i_mi_addr == ADDR_EXPANSION) begin
            nxt_st.rdata = exp_value;
            nxt_st.pdf   = 1'b0;
            nxt_st.prx   = 1'b0;
         end else if (i_mi_addr == ADDR_NEXT_PAGE_TX) begin
            nxt_st.rdata = npt_view;
         end else if (i_mi_addr >= ADDR_VENDOR_LO && i_mi_addr <= ADDR_VENDOR_HI) begin
            // vendor bank only behind management port
            nxt_st.rdata      = i_vendor_rdata;
            nxt_st.vendor_sel = 1'b1;
         end
      end else if (i_mi_wr && i_mi_addr >= ADDR_VENDOR_LO
                   && i_mi_addr <= ADDR_VENDOR_HI) begin
         nxt_st.vendor_sel = 1'b1;
      end

      // restart of negotiation resets the page exchange
      if (i_an_start) begin
         nxt_st.toggle     = TOGGLE_FIRST;
         nxt_st.np_done    = 1'b0;
         nxt_st.partner_an = 1'b0;
      end

      // wait timer with zero or several ready detectors
      if (i_wait_done && !one_ready) begin
         nxt_st.pdf = 1'b1;
      end

      if (page_stored) begin
         // raw word kept, view follows page kind
         nxt_st.partner      = page_word;
         nxt_st.partner_next = page_is_next;
         nxt_st.prx          = 1'b1;
         if (!page_is_next) begin
            nxt_st.partner_np = page_word[LCW_MORE_PAGES_POS];
            nxt_st.partner_an = 1'b1;
         end else if (!page_word[LCW_MORE_PAGES_POS]
                      && !st_ff.npt[LCW_MORE_PAGES_POS]) begin
            nxt_st.np_done = 1'b1;
         end
      end

      // each sent page flips the toggle unless a restart comes in the same cycle
      if (i_tx_page_sent && !i_an_start) begin
         nxt_st.toggle     = ~st_ff.toggle;
         nxt_st.npt_loaded = 1'b0;
      end

      // pause bit used nowhere but the base word
      nxt_st.tx_base = st_ff.adv;

      if (st_ff.npt_loaded) begin
         // fields pass as management set them
         nxt_st.tx_next = st_ff.npt;
      end else begin
         nxt_st.tx_next = NPT_NULL_PAGE;
      end
      nxt_st.tx_next[LCW_TOGGLE_POS] = st_ff.toggle;

      nxt_st.page_valid = i_an_complete;
   end

   always_ff @(posedge i_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         st_ff            <= '0;
         st_ff.adv        <= ADV_RESET;
         st_ff.partner    <= PARTNER_RESET;
         st_ff.npt        <= NPT_NULL_PAGE;
         st_ff.toggle     <= TOGGLE_FIRST;
         st_ff.tx_base    <= ADV_RESET;
         st_ff.tx_next    <= NPT_NULL_PAGE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign o_mi_rdata        = st_ff.rdata;
   assign o_mi_rvalid       = st_ff.rvalid;
   assign o_vendor_sel      = st_ff.vendor_sel;
   assign o_tx_base_word    = st_ff.tx_base;
   assign o_tx_next_word    = st_ff.tx_next;
   assign o_local_np_able   = st_ff.init_done & LOCAL_NEXTPAGE_ABLE;
   assign o_page_received   = st_ff.prx;
   assign o_partner_is_next = st_ff.partner_next;
   assign o_np_done         = st_ff.np_done;
   assign o_page_valid      = st_ff.page_valid;

   // ****************************************
   // assertions
   // ****************************************
   property p_selector;
      @(posedge i_clk) disable iff (!i_rstn)
      st_ff.adv[4:0] == STANDARD_SELECTOR && o_tx_base_word[4:0] == STANDARD_SELECTOR;
   endproperty
   a_selector: assert property (p_selector) else $error("selector not standard");

   property p_ability_init;
      @(posedge i_clk) disable iff (!i_rstn)
      !st_ff.init_done |=> st_ff.adv[9:5] == $past(i_status_caps);
   endproperty
   a_ability_init: assert property (p_ability_init) else $error("abilities not loaded");

   property p_partner_ro;
      @(posedge i_clk) disable iff (!i_rstn)
      i_mi_wr && i_mi_addr == ADDR_PARTNER && !page_stored |=> $stable(st_ff.partner);
   endproperty
   a_partner_ro: assert property (p_partner_ro) else $error("partner written by write");

   property p_page_rx;
      @(posedge i_clk) disable iff (!i_rstn)
      page_stored |=> o_page_received && o_partner_is_next == $past(page_is_next)
                      && st_ff.partner == $past(page_word);
   endproperty
   a_page_rx: assert property (p_page_rx) else $error("page not stored");

   property p_pdf_set;
      @(posedge i_clk) disable iff (!i_rstn)
      i_wait_done && $countones(i_detect_ready) != 32'h1 |=> st_ff.pdf;
   endproperty
   a_pdf_set: assert property (p_pdf_set) else $error("fault not flagged");

   property p_exp_clear;
      @(posedge i_clk) disable iff (!i_rstn)
      i_mi_rd && i_mi_addr == ADDR_EXPANSION && !page_stored && !i_wait_done
      |=> !st_ff.pdf && !st_ff.prx && o_mi_rvalid;
   endproperty
   a_exp_clear: assert property (p_exp_clear) else $error("read did not clear");

   property p_exp_ro;
      @(posedge i_clk) disable iff (!i_rstn)
      i_mi_wr && i_mi_addr == ADDR_EXPANSION && !i_mi_rd && !page_stored && !i_wait_done
      && !i_an_start |=> $stable(exp_value);
   endproperty
   a_exp_ro: assert property (p_exp_ro) else $error("expansion took a write");

   property p_toggle;
      @(posedge i_clk) disable iff (!i_rstn)
      i_tx_page_sent && !i_an_start
      |-> ##2 o_tx_next_word[LCW_TOGGLE_POS] != $past(o_tx_next_word[LCW_TOGGLE_POS]);
   endproperty
   a_toggle: assert property (p_toggle) else $error("toggle did not alternate");

   property p_null_page;
      @(posedge i_clk) disable iff (!i_rstn)
      !st_ff.npt_loaded |=> o_tx_next_word[15:12] == NPT_NULL_PAGE[15:12]
                            && o_tx_next_word[10:0] == NPT_NULL_PAGE[10:0];
   endproperty
   a_null_page: assert property (p_null_page) else $error("non-null page sent");

   property p_toggle_owned;
      @(posedge i_clk) disable iff (!i_rstn)
      i_mi_wr && i_mi_addr == ADDR_NEXT_PAGE_TX && !i_tx_page_sent && !i_an_start
      |=> st_ff.toggle == $past(st_ff.toggle);
   endproperty
   a_toggle_owned: assert property (p_toggle_owned) else $error("write moved toggle");

   property p_valid;
      @(posedge i_clk) disable iff (!i_rstn)
      ##1 o_page_valid == $past(i_an_complete);
   endproperty
   a_valid: assert property (p_valid) else $error("valid not following completion");

   property p_np_done;
      @(posedge i_clk) disable iff (!i_rstn)
      page_stored && page_is_next && !page_word[LCW_MORE_PAGES_POS]
      && !st_ff.npt[LCW_MORE_PAGES_POS] |=> o_np_done;
   endproperty
   a_np_done: assert property (p_np_done) else $error("exchange end missed");

   property p_cov_next;
      @(posedge i_clk) disable iff (!i_rstn)
      page_stored && page_is_next;
   endproperty
   c_cov_next: cover property (p_cov_next);

   property p_cov_fault;
      @(posedge i_clk) disable iff (!i_rstn)
      st_ff.pdf ##1 i_mi_rd && i_mi_addr == ADDR_EXPANSION;
   endproperty
   c_cov_fault: cover property (p_cov_fault);

   property p_cov_loaded;
      @(posedge i_clk) disable iff (!i_rstn)
      i_mi_wr && i_mi_addr == ADDR_NEXT_PAGE_TX ##[1:20] i_tx_page_sent;
   endproperty
   c_cov_loaded: cover property (p_cov_loaded);

endmodule

// >>> tb/anpr_partner.sv
module anpr_partner
   import anpr_pkg::*;
(
   // clock
   input  wire logic        i_clk,
   // link code words toward the device
   output logic             o_valid,
   output logic [15:0]      o_word,
   output logic             o_is_next
);
   timeunit 1ns;
   timeprecision 1ps;

   // base page counts as a transmitted toggle of 0
   logic last_tgl = 1'b0;

   initial begin
      o_valid = 1'b0;
      o_word = 16'h0000;
      o_is_next = 1'b0;
   end

   task automatic send(input logic [15:0] w, input logic nxt, input logic able,
                       input int n, output logic [15:0] s);
      s = w;
      if (nxt) begin
         s[LCW_TOGGLE_POS] = ~last_tgl;
         s[LCW_SECOND_ACKNOWLEDGE_POS] = able;
         last_tgl = s[LCW_TOGGLE_POS];
      end
      repeat (n) begin
         @(negedge i_clk);
         o_valid = 1'b1;
         o_word = s;
         o_is_next = nxt;
      end
      @(negedge i_clk);
      o_valid = 1'b0;
      // idle lines must not look like a held word
      o_word = ~s;
   endtask
endmodule

// >>> tb/tb_anpr_top.sv
module tb_anpr_top
   import anpr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ****
   // signals
   // ****
   logic        clk, rstn, rd, wr, vsel, rvalid, an_st, an_cp, rxv, rxn, wdone, tsent;
   logic        lnp, prcv, pnext, npd, pval, vs, m_tgl, m_pdf, m_pnp, m_prx, m_pan;
   logic [4:0]  addr, caps;
   logic [2:0]  dready;
   logic [15:0] wdata, rdata, vrd, rxw, txb, txn, m_adv, m_npt, s, d, w;
   int          errors, n_tests, cyc;

   anpr_top uut (
      .i_clk(clk), .i_rstn(rstn), .i_mi_addr(addr), .i_mi_rd(rd), .i_mi_wr(wr),
      .i_mi_wdata(wdata), .o_mi_rdata(rdata), .o_mi_rvalid(rvalid),
      .i_vendor_rdata(vrd), .o_vendor_sel(vsel), .i_status_caps(caps),
      .i_an_start(an_st), .i_an_complete(an_cp), .i_rx_valid(rxv), .i_rx_word(rxw),
      .i_rx_is_next(rxn), .i_wait_done(wdone), .i_detect_ready(dready),
      .i_tx_page_sent(tsent), .o_tx_base_word(txb), .o_tx_next_word(txn),
      .o_local_np_able(lnp), .o_page_received(prcv), .o_partner_is_next(pnext),
      .o_np_done(npd), .o_page_valid(pval)
   );

   anpr_partner u_partner (.i_clk(clk), .o_valid(rxv), .o_word(rxw), .o_is_next(rxn));

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ****
   // tasks
   // ****
   task automatic close_out();
      if (errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // generous ceiling: the sequence needs well under two thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end

   task automatic chkw(input logic [15:0] g, input logic [15:0] e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic chkb(input logic g, input logic e);
      n_tests++;
      if (g !== e) begin
         errors++;
         $display("wrong value t=%0t got %h exp %h", $time, g, e);
      end
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic mi_wr(input logic [4:0] a, input logic [15:0] v);
      @(negedge clk);
      addr = a;
      wdata = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic mi_rd(input logic [4:0] a);
      int k;
      k = 0;
      vs = 1'b0;
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      while (rvalid !== 1'b1 && k < 4) begin
         vs = vs | (vsel === 1'b1);
         @(negedge clk);
         k++;
      end
      vs = vs | (vsel === 1'b1);
      d = rdata;
      chkb(rvalid, 1'b1);
   endtask

   task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
      mi_rd(a);
      chkw(d, e);
   endtask

   function logic [15:0] exp6();
      return {11'h0, m_pdf, m_pnp, LOCAL_NEXTPAGE_ABLE, m_prx, m_pan};
   endfunction

   // toggle is always the device's own
   function logic [15:0] npt(input logic [15:0] v);
      return (v & 16'hf7ff) | {4'h0, m_tgl, 11'h0};
   endfunction

   // ****
   // sequence
   // ****
   initial begin
      void'($urandom(32'h68cacd9f));
      {rstn, rd, wr, an_st, an_cp, wdone, tsent} = '0;
      {addr, wdata, vrd, dready} = '0;
      caps = 5'($urandom);
      {m_pdf, m_pnp, m_prx, m_pan} = '0;
      m_adv = {6'h0, caps, STANDARD_SELECTOR};
      m_npt = NPT_NULL_PAGE;
      m_tgl = TOGGLE_FIRST;
      repeat (16) @(negedge clk);
      rstn = 1'b1;
      cyc_n(3);
      rd_chk(ADDR_ADVERTISE, m_adv);
      chkw(txb, m_adv);
      rd_chk(ADDR_NEXT_PAGE_TX, npt(m_npt));
      chkw(txn, npt(m_npt));
      rd_chk(ADDR_EXPANSION, exp6());
      chkb(lnp, 1'b1);
      rd_chk(ADDR_PARTNER, PARTNER_RESET);
      repeat (4) begin
         w = 16'($urandom);
         mi_wr(ADDR_ADVERTISE, w);
         m_adv = (w & ADV_WRITE_MASK) | (m_adv & ~ADV_WRITE_MASK);
         rd_chk(ADDR_ADVERTISE, m_adv);
         chkw(txb, m_adv);
      end
      mi_wr(ADDR_PARTNER, 16'($urandom));
      mi_wr(ADDR_EXPANSION, 16'hffff);
      rd_chk(ADDR_PARTNER, PARTNER_RESET);
      rd_chk(ADDR_EXPANSION, exp6());
      // two matches then a different word must not store
      w = 16'($urandom) | 16'h8000;
      u_partner.send(w, 1'b0, 1'b0, 2, s);
      u_partner.send(~w, 1'b0, 1'b0, 1, s);
      cyc_n(4);
      chkb(prcv, 1'b0);
      u_partner.send(w, 1'b0, 1'b0, 3, s);
      cyc_n(3);
      chkb(prcv, 1'b1);
      chkb(pnext, 1'b0);
      rd_chk(ADDR_PARTNER, s);
      {m_prx, m_pan, m_pnp} = {2'b11, s[LCW_MORE_PAGES_POS]};
      rd_chk(ADDR_EXPANSION, exp6());
      m_prx = 1'b0;
      u_partner.send(w, 1'b0, 1'b0, 1, s);
      cyc_n(3);
      rd_chk(ADDR_EXPANSION, exp6());
      for (int v = 0; v < 8; v++) begin
         dready = 3'(v);
         wdone = 1'b1;
         cyc_n(1);
         wdone = 1'b0;
         m_pdf = ($countones(dready) != 1);
         cyc_n(1);
         rd_chk(ADDR_EXPANSION, exp6());
         m_pdf = 1'b0;
      end
      rd_chk(ADDR_EXPANSION, exp6());
      w = (16'($urandom) | 16'h8000) & 16'hf7ff;
      mi_wr(ADDR_NEXT_PAGE_TX, w);
      m_npt = w & NPT_WRITE_MASK;
      rd_chk(ADDR_NEXT_PAGE_TX, npt(m_npt));
      chkw(txn, npt(m_npt));
      u_partner.send(16'($urandom) & 16'h7fff, 1'b1, 1'b1, 3, s);
      cyc_n(3);
      chkb(pnext, 1'b1);
      rd_chk(ADDR_PARTNER, s);
      m_prx = 1'b1;
      rd_chk(ADDR_EXPANSION, exp6());
      m_prx = 1'b0;
      chkb(npd, 1'b0);
      tsent = 1'b1;
      cyc_n(1);
      tsent = 1'b0;
      cyc_n(2);
      m_tgl = ~m_tgl;
      chkw(txn, npt(NPT_NULL_PAGE));
      w = (16'($urandom) & 16'h7fff) | 16'h0800;
      mi_wr(ADDR_NEXT_PAGE_TX, w);
      m_npt = w & NPT_WRITE_MASK;
      cyc_n(2);
      chkw(txn, npt(m_npt));
      u_partner.send(16'($urandom) & 16'h7fff, 1'b1, 1'b0, 3, s);
      cyc_n(3);
      chkb(npd, 1'b1);
      chkb(prcv, 1'b1);
      for (int a = 8; a < 32; a++) begin
         logic hit;
         hit = (5'(a) >= ADDR_VENDOR_LO) && (5'(a) <= ADDR_VENDOR_HI);
         vrd = 16'($urandom);
         mi_rd(5'(a));
         chkw(d, hit ? vrd : 16'h0000);
         chkb(vs, hit);
      end
      mi_wr(ADDR_VENDOR_HI, 16'($urandom));
      chkb(vsel, 1'b1);
      chkb(pval, 1'b0);
      an_cp = 1'b1;
      cyc_n(1);
      chkb(pval, 1'b1);
      an_cp = 1'b0;
      cyc_n(2);
      chkb(pval, 1'b0);
      an_st = 1'b1;
      cyc_n(1);
      an_st = 1'b0;
      cyc_n(3);
      chkb(txn[LCW_TOGGLE_POS], TOGGLE_FIRST);
      chkb(npd, 1'b0);
      mi_rd(ADDR_EXPANSION);
      chkw(d & 16'h0001, 16'h0000);
      close_out();
   end
endmodule
